// ### include/bss_regs.svh
// timing counts and settle figures for the boot source selector
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH
`define BSS_CLK_NS 25
`define BSS_MS_NS 1000000
`define BSS_MS_CYC (`BSS_MS_NS / `BSS_CLK_NS)
`define BSS_LONG_WIN_MS 60000
`define BSS_SHORT_WIN_MS 100
`define BSS_RESTART_MS 3
`define BSS_SETTLE_CYC 16
`endif

// ### include/bss_pkg.sv
// types shared by the boot source selector
package bss_pkg;
    // one-hot boot sequencer states
    typedef enum logic [9:0] {
        BSS_RESTART  = 10'h001,
        BSS_PROBE_UP = 10'h002,
        BSS_PROBE_DN = 10'h004,
        BSS_DECIDE   = 10'h008,
        BSS_SER_SHRT = 10'h010,
        BSS_FLASH    = 10'h020,
        BSS_CARD     = 10'h040,
        BSS_SER_LONG = 10'h080,
        BSS_RUN      = 10'h100,
        BSS_SHUTDOWN = 10'h200
    } bss_state_t;
endpackage

// ### hw/bss_boot_selector.sv
// boot source selector: switch probe, serial windows, flash/card boot, led buffer
//
// Notes on behaviour
// - all off, no card: 60 s serial
// - up switch only: 60 s serial only
// - flash only: 100 ms serial, flash, 60 s
// - flash plus down: flash only, fail shuts down
// - all off with card: card, else 60 s
// - down only: card only, fail shuts down
// - led lights while its line is high
// - all lines float after reset
// - card uses data, cmd, select, clock lines
// - flash swaps clock and select lines
// - both switches share one line, pulled
// - reset holds off; restart 3 ms later
// - every reset re-reads switches
`include "bss_regs.svh"
module bss_boot_selector
    import bss_pkg::*;
#(
    parameter int P_MS_CYCLES = `BSS_MS_CYC,
    parameter int P_LONG_MS = `BSS_LONG_WIN_MS,
    parameter int P_SHORT_MS = `BSS_SHORT_WIN_MS,
    parameter int P_RESTART_MS = `BSS_RESTART_MS
)
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_flash_switch,
    input wire logic i_shared_spi_data_in,
    input wire logic i_shared_spi_data_out_bootsel,
    output logic o_shared_spi_data_out_bootsel,
    output logic o_shared_spi_data_out_bootsel_oe_n,
    output logic o_bootsel_pull_up,
    output logic o_bootsel_pull_dn,
    output logic o_card_select_flash_clock,
    output logic o_card_select_flash_clock_oe_n,
    output logic o_card_clock_flash_select,
    output logic o_card_clock_flash_select_oe_n,
    input wire logic i_eng_sclk,
    input wire logic i_eng_mosi,
    input wire logic i_eng_cs_n,
    output logic o_eng_miso,
    output logic o_flash_load_start,
    output logic o_card_load_start,
    input wire logic i_load_ok,
    input wire logic i_load_fail,
    output logic o_serial_window,
    input wire logic i_serial_loaded,
    output logic o_core_enable,
    output logic o_shutdown,
    input wire logic i_led_line_a,
    input wire logic i_led_line_b,
    output logic o_led_a,
    output logic o_led_b
);
    localparam int SETTLE = `BSS_SETTLE_CYC;

    // refuse figures the counters cannot hold
    if (P_MS_CYCLES < 1 || P_MS_CYCLES > 16777215 || P_LONG_MS < 1 || P_LONG_MS > 65535
        || P_SHORT_MS < 1 || P_SHORT_MS > 65535 || P_RESTART_MS < 1 || P_RESTART_MS > 65535)
    begin : g_bad_param
        $error("bss_boot_selector: timing parameter out of range");
    end

    logic rst_a_r; // reset release, first stage
    logic rst_q_r; // synchronised reset, active low
    logic [4:0] pin_raw; // asynchronous pin inputs
    logic [4:0] sync1_r; // first synchroniser stage
    logic [4:0] sync2_r; // synchronised copy
    bss_state_t state_r; // sequencer state
    bss_state_t state_nxt;
    logic [23:0] div_r; // millisecond divider
    logic ms_tick; // one-cycle millisecond enable
    logic [15:0] ms_r; // milliseconds in the current state
    logic [4:0] settle_r; // probe settle counter
    logic up_on_r; // up switch seen
    logic dn_on_r; // down switch seen
    logic flash_on_r; // flash switch seen
    logic short_done_r; // short window already offered
    logic st_chg; // state changes this cycle
    logic win_end; // current window timed out

    // release reset through two flops
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_a_r <= 1'b0;
            rst_q_r <= 1'b0;
        end
        else
        begin
            rst_a_r <= 1'b1;
            rst_q_r <= rst_a_r;
        end
    end

    // two-flop synchronisers for every pin input
    assign pin_raw = {i_flash_switch, i_led_line_b, i_led_line_a,
                      i_shared_spi_data_out_bootsel, i_shared_spi_data_in};
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end
        else
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // led buffer only listens, lights while line high
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            o_led_a <= 1'b0;
            o_led_b <= 1'b0;
        end
        else
        begin
            o_led_a <= sync2_r[2];
            o_led_b <= sync2_r[3];
        end
    end

    // millisecond tick, restarted on each state change
    assign st_chg = (state_nxt != state_r);
    assign ms_tick = (div_r == 24'(P_MS_CYCLES - 1));
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            div_r <= 24'h000000;
            ms_r <= 16'h0000;
        end
        else if (st_chg)
        begin
            div_r <= 24'h000000;
            ms_r <= 16'h0000;
        end
        else if (ms_tick)
        begin
            div_r <= 24'h000000;
            ms_r <= ms_r + 16'h0001;
        end
        else
        begin
            div_r <= div_r + 24'h000001;
        end
    end

    // window length depends on which window is open
    always_comb
    begin
        win_end = 1'b0;
        if (state_r == BSS_SER_SHRT)
            win_end = ms_tick && (ms_r == 16'(P_SHORT_MS - 1));
        else if (state_r == BSS_SER_LONG)
            win_end = ms_tick && (ms_r == 16'(P_LONG_MS - 1));
    end

    // settle counter for the two probe phases
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
            settle_r <= 5'h00;
        else if (st_chg)
            settle_r <= 5'h00;
        else if (settle_r != 5'(SETTLE))
            settle_r <= settle_r + 5'h01;
    end

    // latch switch readings, one line read twice
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            up_on_r <= 1'b0;
            dn_on_r <= 1'b0;
            flash_on_r <= 1'b0;
        end
        else if (settle_r == 5'(SETTLE))
        begin
            // low against own pull-up means down switch on
            if (state_r == BSS_PROBE_UP)
                dn_on_r <= !sync2_r[1];
            // high against own pull-down means up switch on
            if (state_r == BSS_PROBE_DN)
            begin
                up_on_r <= sync2_r[1];
                flash_on_r <= sync2_r[4];
            end
        end
    end

    // next state of the boot sequence
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            BSS_RESTART:
                if (ms_tick && ms_r == 16'(P_RESTART_MS - 1))
                    state_nxt = BSS_PROBE_UP;
            BSS_PROBE_UP:
                if (settle_r == 5'(SETTLE))
                    state_nxt = BSS_PROBE_DN;
            BSS_PROBE_DN:
                if (settle_r == 5'(SETTLE))
                    state_nxt = BSS_DECIDE;
            BSS_DECIDE:
                if (up_on_r && !dn_on_r)
                    state_nxt = BSS_SER_LONG;
                else if (flash_on_r && dn_on_r)
                    state_nxt = BSS_FLASH;
                else if (flash_on_r)
                    state_nxt = BSS_SER_SHRT;
                else
                    state_nxt = BSS_CARD;
            BSS_SER_SHRT:
                if (i_serial_loaded)
                    state_nxt = BSS_RUN;
                else if (win_end)
                    state_nxt = BSS_FLASH;
            BSS_FLASH:
                if (i_load_ok)
                    state_nxt = BSS_RUN;
                else if (i_load_fail)
                    state_nxt = dn_on_r ? BSS_SHUTDOWN : BSS_SER_LONG;
            BSS_CARD:
                if (i_load_ok)
                    state_nxt = BSS_RUN;
                else if (i_load_fail)
                    state_nxt = dn_on_r ? BSS_SHUTDOWN : BSS_SER_LONG;
            BSS_SER_LONG:
                if (i_serial_loaded)
                    state_nxt = BSS_RUN;
                else if (win_end)
                    state_nxt = BSS_SHUTDOWN;
            BSS_RUN:
                state_nxt = BSS_RUN;
            BSS_SHUTDOWN:
                state_nxt = BSS_SHUTDOWN;
            default:
                state_nxt = BSS_RESTART;
        endcase
    end

    // state register, every reset starts over
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
            state_r <= BSS_RESTART;
        else
            state_r <= state_nxt;
    end

    // short window history, one-cycle loader start pulses
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            short_done_r <= 1'b0;
            o_flash_load_start <= 1'b0;
            o_card_load_start <= 1'b0;
        end
        else
        begin
            if (state_r == BSS_SER_SHRT)
                short_done_r <= 1'b1;
            o_flash_load_start <= st_chg && (state_nxt == BSS_FLASH);
            o_card_load_start <= st_chg && (state_nxt == BSS_CARD);
        end
    end

    // pin drive and status; lines float outside loader states
    always_ff @(posedge i_clk_sys or negedge rst_q_r)
    begin
        if (!rst_q_r)
        begin
            o_shared_spi_data_out_bootsel <= 1'b0;
            o_shared_spi_data_out_bootsel_oe_n <= 1'b1;
            o_card_select_flash_clock <= 1'b0;
            o_card_select_flash_clock_oe_n <= 1'b1;
            o_card_clock_flash_select <= 1'b0;
            o_card_clock_flash_select_oe_n <= 1'b1;
            o_bootsel_pull_up <= 1'b0;
            o_bootsel_pull_dn <= 1'b0;
            o_eng_miso <= 1'b0;
            o_serial_window <= 1'b0;
            o_core_enable <= 1'b0;
            o_shutdown <= 1'b0;
        end
        else
        begin
            o_bootsel_pull_up <= (state_nxt == BSS_PROBE_UP);
            o_bootsel_pull_dn <= (state_nxt == BSS_PROBE_DN);
            o_eng_miso <= sync2_r[0];
            o_shared_spi_data_out_bootsel <= i_eng_mosi;
            if (state_nxt == BSS_FLASH)
            begin
                o_card_select_flash_clock <= i_eng_sclk;
                o_card_clock_flash_select <= i_eng_cs_n;
            end
            else
            begin
                o_card_select_flash_clock <= i_eng_cs_n;
                o_card_clock_flash_select <= i_eng_sclk;
            end
            o_shared_spi_data_out_bootsel_oe_n <=
                !(state_nxt == BSS_FLASH || state_nxt == BSS_CARD);
            o_card_select_flash_clock_oe_n <=
                !(state_nxt == BSS_FLASH || state_nxt == BSS_CARD);
            o_card_clock_flash_select_oe_n <=
                !(state_nxt == BSS_FLASH || state_nxt == BSS_CARD);
            o_serial_window <= (state_nxt == BSS_SER_SHRT) || (state_nxt == BSS_SER_LONG);
            o_core_enable <= (state_nxt == BSS_RUN);
            o_shutdown <= (state_nxt == BSS_SHUTDOWN);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_q_r);

    a_up_long_win: assert property (
        (state_r == BSS_DECIDE) && up_on_r && !dn_on_r
        |=> (state_r == BSS_SER_LONG) && o_serial_window)
        else $error("up switch did not open long window");
    a_flash_fast: assert property (
        (state_r == BSS_DECIDE) && flash_on_r && dn_on_r && !up_on_r
        |=> (state_r == BSS_FLASH) && !o_serial_window)
        else $error("fast flash boot opened a window");
    a_flash_shut: assert property (
        (state_r == BSS_FLASH) && i_load_fail && !i_load_ok && dn_on_r
        |=> ##1 o_shutdown && !o_core_enable)
        else $error("flash failure did not shut down");
    a_short_to_flash: assert property (
        win_end && (state_r == BSS_SER_SHRT) && !i_serial_loaded
        |=> (state_r == BSS_FLASH) ##1 !o_serial_window)
        else $error("short window did not lead to flash");
    a_card_fallback: assert property (
        (state_r == BSS_CARD) && i_load_fail && !i_load_ok && !dn_on_r
        |=> (state_r == BSS_SER_LONG))
        else $error("card failure did not open long window");
    a_card_shut: assert property (
        (state_r == BSS_CARD) && i_load_fail && !i_load_ok && dn_on_r
        |=> ##1 o_shutdown)
        else $error("card only failure did not shut down");
    a_lines_float: assert property (
        !(state_r inside {BSS_FLASH, BSS_CARD}) && !(state_nxt inside {BSS_FLASH, BSS_CARD})
        |=> o_card_select_flash_clock_oe_n && o_card_clock_flash_select_oe_n
        && o_shared_spi_data_out_bootsel_oe_n)
        else $error("line driven outside a loader state");
    a_flash_roles: assert property (
        (state_nxt == BSS_FLASH) && (state_r == BSS_FLASH)
        |=> o_card_clock_flash_select == $past(i_eng_cs_n)
        && o_card_select_flash_clock == $past(i_eng_sclk))
        else $error("flash line roles not swapped");
    a_card_roles: assert property (
        (state_r == BSS_CARD) && (state_nxt == BSS_CARD)
        |=> o_card_select_flash_clock == $past(i_eng_cs_n)
        && o_card_clock_flash_select == $past(i_eng_sclk))
        else $error("card line roles wrong");
    a_led_follow: assert property (i_led_line_a [*4] |-> o_led_a)
        else $error("led did not follow its line");
    a_core_hold: assert property (
        (state_r != BSS_RUN) && (state_nxt != BSS_RUN) |=> !o_core_enable)
        else $error("core enabled before boot finished");

    c_serial_boot: cover property ((state_r == BSS_SER_LONG) && i_serial_loaded);
    c_flash_boot: cover property ((state_r == BSS_FLASH) && i_load_ok && short_done_r);
    c_card_boot: cover property ((state_r == BSS_CARD) && i_load_ok);
    c_shutdown: cover property ($rose(o_shutdown));
endmodule

// ### sim/bss_far_side.sv
// far side model: switches on the shared pin, loader results, data line
module bss_far_side (
    input wire logic i_clk_sys,
    input wire logic i_up_on,
    input wire logic i_dn_on,
    input wire logic i_fail,
    input wire logic i_pull_up,
    input wire logic i_pull_dn,
    input wire logic i_drv,
    input wire logic i_drv_oe_n,
    input wire logic i_pin_c,
    input wire logic i_pin_c_oe_n,
    input wire logic i_pin_d,
    input wire logic i_pin_d_oe_n,
    input wire logic i_start,
    output logic o_wire,
    output logic o_data,
    output logic o_load_ok,
    output logic o_load_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_r = 1'b0; // changes every cycle for a floating line
    logic [4:0] cnt_r = 5'h00; // loader busy count
    logic sel; // some target selected by a low select pin
    // card select on one pin, flash select on the other
    assign sel = (!i_pin_c_oe_n && !i_pin_c) || (!i_pin_d_oe_n && !i_pin_d);
    // released data line shows a moving pattern
    assign o_data = sel ? cnt_r[0] : flip_r;
    // strong switch resistors beat the device weak pulls
    always_comb
    begin
        if (!i_drv_oe_n)
            o_wire = i_drv;
        else if (i_dn_on)
            o_wire = 1'b0;
        else if (i_up_on)
            o_wire = 1'b1;
        else if (i_pull_up || i_pull_dn)
            o_wire = i_pull_up;
        else
            o_wire = flip_r;
    end
    // loader answers 20 cycles after a start; absent card reports fail
    always_ff @(posedge i_clk_sys)
    begin
        flip_r <= ~flip_r;
        o_load_ok <= 1'b0;
        o_load_fail <= 1'b0;
        if (i_start)
            cnt_r <= 5'h14;
        else if (cnt_r != 5'h00)
        begin
            cnt_r <= cnt_r - 5'h01;
            o_load_ok <= (cnt_r == 5'h01) && !i_fail;
            o_load_fail <= (cnt_r == 5'h01) && i_fail;
        end
    end
endmodule

// ### sim/boot_source_selector_bench.sv
// self-checking bench for the boot source selector
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t %s", $time, m); end end
module boot_source_selector_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, fl = 1'b0, up = 1'b0, dn = 1'b0, fail = 1'b0;
    logic sclk = 1'b0, mosi = 1'b0, cs_n = 1'b1, ser = 1'b0, led_a = 1'b0, led_b = 1'b0;
    logic wire_lvl, din, ok, bad, drv, drv_oe_n, pu, pd, pc, pc_oe_n, pdd, pd_oe_n;
    logic miso, fst, cst, win, core, shut, o_a, o_b;
    logic seen_f = 1'b0, seen_c = 1'b0, seen_w = 1'b0; // sticky event flags
    logic [2:0] din_d = 3'h0; // data in line, as sampled over the last three edges
    int mismatches = 0, total_checks = 0, n;
    always #12.5 clk = ~clk;
    // catch one-cycle start pulses and any window; cleared while in reset
    always @(posedge clk)
    begin
        if (!rstn)
            {seen_f, seen_c, seen_w} <= 3'h0;
        else
        begin
            seen_f <= seen_f | fst;
            seen_c <= seen_c | cst;
            seen_w <= seen_w | win;
        end
        din_d <= {din_d[1:0], din};
    end
    bss_boot_selector #(.P_MS_CYCLES(4), .P_LONG_MS(20), .P_SHORT_MS(5)) i_dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_flash_switch(fl),
        .i_shared_spi_data_in(din), .i_shared_spi_data_out_bootsel(wire_lvl),
        .o_shared_spi_data_out_bootsel(drv), .o_shared_spi_data_out_bootsel_oe_n(drv_oe_n),
        .o_bootsel_pull_up(pu), .o_bootsel_pull_dn(pd),
        .o_card_select_flash_clock(pc), .o_card_select_flash_clock_oe_n(pc_oe_n),
        .o_card_clock_flash_select(pdd), .o_card_clock_flash_select_oe_n(pd_oe_n),
        .i_eng_sclk(sclk), .i_eng_mosi(mosi), .i_eng_cs_n(cs_n), .o_eng_miso(miso),
        .o_flash_load_start(fst), .o_card_load_start(cst), .i_load_ok(ok),
        .i_load_fail(bad), .o_serial_window(win), .i_serial_loaded(ser),
        .o_core_enable(core), .o_shutdown(shut), .i_led_line_a(led_a),
        .i_led_line_b(led_b), .o_led_a(o_a), .o_led_b(o_b));
    bss_far_side i_far (.i_clk_sys(clk), .i_up_on(up), .i_dn_on(dn), .i_fail(fail),
        .i_pull_up(pu), .i_pull_dn(pd), .i_drv(drv), .i_drv_oe_n(drv_oe_n), .i_pin_c(pc),
        .i_pin_c_oe_n(pc_oe_n), .i_pin_d(pdd), .i_pin_d_oe_n(pd_oe_n), .i_start(fst | cst),
        .o_wire(wire_lvl), .o_data(din), .o_load_ok(ok), .o_load_fail(bad));
    // reset with new switch settings, check the quiet state
    task automatic boot(input logic f, input logic u, input logic d, input logic e);
        @(negedge clk);
        rstn = 1'b0;
        {fl, up, dn, fail, ser} = {f, u, d, e, 1'b0};
        repeat (6) @(negedge clk);
        `CHK({core, win, shut, fst, cst}, 5'h00, "not quiet in reset")
        `CHK({drv_oe_n, pc_oe_n, pd_oe_n}, 3'h7, "pin driven in reset")
        rstn = 1'b1;
        // two release edges, then 3 ms of 4 cycles before the first probe
        repeat (12) @(negedge clk);
        `CHK(pu, 1'b0, "probe before restart delay")
        repeat (3) @(negedge clk);
        `CHK(pu, 1'b1, "probe did not start")
    endtask
    // wait for a watched signal to reach a level, bounded
    task automatic wait_for(input int s, input logic lv, input int lim);
        logic v;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            case (s)
                0: v = win;
                1: v = seen_f;
                2: v = seen_c;
                3: v = core;
                default: v = shut;
            endcase
        end
        while (v !== lv && n < lim);
        `CHK(v, lv, "wait ran out")
    endtask
    // one-cycle serial code arrival, then run within a few cycles
    task automatic load_serial();
        ser = 1'b1;
        @(negedge clk);
        ser = 1'b0;
        wait_for(3, 1'b1, 5);
    endtask
    // toggle the engine clock with select low and check which pin carries each line
    task automatic pin_roles(input logic fl_state);
        cs_n = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            sclk = k[0];
            mosi = !k[0];
            repeat (4) @(negedge clk);
            `CHK({pc_oe_n, pd_oe_n, drv_oe_n}, 3'h0, "pins not driven")
            `CHK(fl_state ? {pc, pdd} : {pdd, pc}, {sclk, cs_n}, "pin roles")
            `CHK(drv, mosi, "data out not passed")
            `CHK(miso, din_d[2], "data in not passed")
        end
        cs_n = 1'b1;
        sclk = 1'b0;
    endtask
    task automatic t_default();
        boot(1'b0, 1'b0, 1'b0, 1'b1);
        wait_for(2, 1'b1, 100);
        wait_for(0, 1'b1, 30);
        wait_for(0, 1'b0, 200);
        `CHK(n >= 79 && n <= 81, 1'b1, "long window length")
        `CHK(shut, 1'b1, "no shutdown after window")
        $display("default boot done");
    endtask
    task automatic t_up_only();
        boot(1'b1, 1'b1, 1'b0, 1'b0);
        wait_for(0, 1'b1, 100);
        repeat (10) @(negedge clk);
        load_serial();
        `CHK({seen_f, seen_c}, 2'h0, "loader used with up switch")
        $display("up switch done");
    endtask
    task automatic t_flash_fallback(input logic e);
        boot(1'b1, 1'b0, 1'b0, e);
        wait_for(0, 1'b1, 100);
        wait_for(0, 1'b0, 40);
        `CHK(n >= 19 && n <= 21, 1'b1, "short window length")
        // the start pulse reaches the sticky flag one edge later
        @(negedge clk);
        `CHK(seen_f, 1'b1, "no flash after short window")
        if (e)
        begin
            wait_for(0, 1'b1, 30);
            load_serial();
        end
        else
            wait_for(3, 1'b1, 30);
        $display("flash fallback done");
    endtask
    task automatic t_short_load();
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        wait_for(0, 1'b1, 100);
        repeat (2) @(negedge clk);
        load_serial();
        `CHK({seen_f, seen_c}, 2'h0, "loader used after early serial code")
        $display("short window load done");
    endtask
    task automatic t_flash_only();
        boot(1'b1, 1'b0, 1'b1, 1'b1);
        wait_for(1, 1'b1, 100);
        pin_roles(1'b1);
        wait_for(4, 1'b1, 30);
        `CHK({seen_w, pc_oe_n, pd_oe_n}, 3'h3, "window or pin after flash fail")
        $display("flash only done");
    endtask
    task automatic t_card(input logic d, input logic e);
        boot(1'b0, 1'b0, d, e);
        wait_for(2, 1'b1, 100);
        pin_roles(1'b0);
        wait_for(e ? 4 : 3, 1'b1, 30);
        `CHK(seen_w, 1'b0, "window in card boot")
        $display("card boot done");
    endtask
    task automatic t_led();
        for (int k = 0; k < 4; k++)
        begin
            {led_a, led_b} = k[1:0];
            repeat (4) @(negedge clk);
            `CHK({o_a, o_b}, k[1:0], "led follows line")
        end
        $display("led buffer done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        t_default();
        t_up_only();
        t_flash_fallback(1'b1);
        t_flash_fallback(1'b0);
        t_short_load();
        t_flash_only();
        t_card(1'b0, 1'b0);
        t_card(1'b1, 1'b1);
        t_led();
        summarize();
    end
    // cut a hang short
    initial
    begin
        #300000;
        mismatches++;
        summarize();
    end
endmodule
